// file: core/psr_pkg.sv
// ============================================================
// Shared constants for the self-ID control and event registers
package psr_pkg;

    // ============================================================
    // Register addresses on the PHY register port
    localparam logic [3:0] ADDR_SELFID_CTRL = 4'h4;
    localparam logic [3:0] ADDR_EVENT_CTRL  = 4'h5;

    // ============================================================
    // Field positions; register bit 7 is the data MSB
    localparam int BIT_LINK_ACTIVE   = 7;
    localparam int BIT_CONTENDER     = 6;
    localparam int BIT_JITTER_HI     = 5;
    localparam int BIT_JITTER_LO     = 3;
    localparam int BIT_PWR_HI        = 2;
    localparam int BIT_PWR_LO        = 0;
    localparam int BIT_RESUME_IE     = 7;
    localparam int BIT_SHORT_RST_REQ = 6;
    localparam int BIT_CFG_TIMEOUT   = 5;
    localparam int BIT_CABLE_PWR     = 4;
    localparam int BIT_STATE_TIMEOUT = 3;
    localparam int BIT_PORT_EVENT    = 2;

    // ============================================================
    // Reset values
    localparam logic       RST_LINK_ACTIVE = 1'b1;
    localparam logic       RST_CONTENDER   = 1'b0;
    localparam logic       RST_RESUME_IE   = 1'b0;
    localparam logic       RST_SHORT_REQ   = 1'b0;
    localparam logic       RST_CFG_TIMEOUT = 1'b0;
    localparam logic       RST_CABLE_PWR   = 1'b1;
    localparam logic       RST_STATE_TO    = 1'b0;
    localparam logic       RST_PORT_EVENT  = 1'b0;
    localparam logic [2:0] JITTER_VALUE    = 3'h0;
    localparam logic [7:0] RDATA_IDLE      = 8'h00;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int SHORT_RESET_NS    = 1300;
    localparam int SHORT_RESET_CYC   = SHORT_RESET_NS / CLK_PERIOD_NS;
    localparam int LONG_RESET_US     = 166;
    localparam int LONG_RESET_CYC    = LONG_RESET_US * 1000 / CLK_PERIOD_NS;
    localparam int RST_CNT_W         = 16;

    typedef enum logic {PSR_RS_IDLE, PSR_RS_ACTIVE} psr_rst_state_t;

endpackage

// file: core/psr_w1c_flag.sv
`timescale 1ns/10ps
// ============================================================
// Sticky event flag: hardware sets, software writes one to clear
module psr_w1c_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic set_evt,
    input  wire logic clr_w1c,
    output logic      flag_q
);
    logic flag_d;

    // Set wins so an event in the clearing cycle is never lost
    always_comb begin
        flag_d = flag_q;
        if (clr_w1c) begin
            flag_d = 1'b0;
        end
        if (set_evt) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_q <= RESET_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

// file: core/psr_regs.sv
`timescale 1ns/10ps
// What this block does
// - Self-ID link bit is control AND power status
// - Link-active control resets to one, survives bus reset
// - Link interface state follows power status only
// - Active power status keeps link interface serviced
// - Contender bit copied into self-ID
// - Contender resets zero, set only by write
// - Repeater jitter field reads zero
// - Power class copied into self-ID
// - Power class loads straps on hardware reset
// - Resume start sets port event when enabled
// - Timeouts while link down set port event when enabled
// - Resume enable resets zero, survives bus reset
// - Short reset request starts short bus reset
// - Short reset request clears on bus reset
// - Legacy node present turns short into long
// - Arbitration tree-ID timeout sets config flag
// - Config flag resets zero, write one clears
// - Config flag with enable wakes inactive link
// - Only loop nodes raise config timeout flag
// - Config flag only with legacy nodes present
// - State timeout sets flag and resets bus
module psr_regs #(
    parameter int LONG_RESET_CYCLES = psr_pkg::LONG_RESET_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_q,
    output logic            reg_rvalid_q,
    input  wire logic       link_power_status_in,
    input  wire logic [2:0] power_class_strap_inputs,
    input  wire logic       resume_start_evt,
    input  wire logic       port_change_evt,
    input  wire logic       arb_treeid_timeout_evt,
    input  wire logic       in_bus_loop,
    input  wire logic       legacy_node_present,
    input  wire logic       state_timeout_evt,
    input  wire logic       cable_power_drop_evt,
    input  wire logic       arb_opportunity,
    input  wire logic       bus_reset_evt,
    output logic            selfid_link_active_q,
    output logic            selfid_contender_q,
    output logic      [2:0] selfid_power_class_q,
    output logic            link_if_operational_q,
    output logic            link_wake_output_q,
    output logic            bus_reset_active_q,
    output logic            bus_reset_long_q,
    output logic            short_reset_request_q,
    output logic            config_timeout_flag_q
);
    import psr_pkg::*;

    // ============================================================
    // Decode
    logic       wr_selfid;
    logic       wr_event;
    logic       link_active_ctrl_q;
    logic       contender_q;
    logic [2:0] power_class_q;
    logic       resume_irq_enable_q;
    logic       cable_power_drop_flag;
    logic       state_timeout_flag;
    logic       port_event_flag;
    logic       cfg_set;
    logic       cpd_set;
    logic       sto_set;
    logic       pev_set;
    logic       reset_start;
    logic       start_long;
    psr_rst_state_t  rs_q;
    logic [RST_CNT_W-1:0] rs_cnt_q;

    function automatic logic w1c(input logic [7:0] data, input int pos);
        return data[pos];
    endfunction

    assign wr_selfid = reg_wr && (reg_addr == ADDR_SELFID_CTRL);
    assign wr_event  = reg_wr && (reg_addr == ADDR_EVENT_CTRL);

    // ============================================================
    // Self-ID control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link_active_ctrl_q <= RST_LINK_ACTIVE;
        end else if (wr_selfid) begin
            link_active_ctrl_q <= reg_wdata[BIT_LINK_ACTIVE];
        end
    end

    // Bus reset has no path into this bit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            contender_q <= RST_CONTENDER;
        end else if (wr_selfid) begin
            contender_q <= reg_wdata[BIT_CONTENDER];
        end
    end

    // Straps are sampled on the clock while reset is held
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_class_q <= power_class_strap_inputs;
        end else if (wr_selfid) begin
            power_class_q <= reg_wdata[BIT_PWR_HI:BIT_PWR_LO];
        end
    end

    // ============================================================
    // Event control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resume_irq_enable_q <= RST_RESUME_IE;
        end else if (wr_event) begin
            resume_irq_enable_q <= reg_wdata[BIT_RESUME_IE];
        end
    end

    // A fresh write request outranks a bus reset in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            short_reset_request_q <= RST_SHORT_REQ;
        end else if (wr_event) begin
            short_reset_request_q <= reg_wdata[BIT_SHORT_RST_REQ];
        end else if (bus_reset_evt || reset_start) begin
            short_reset_request_q <= 1'b0;
        end
    end

    // ============================================================
    // Event flags
    // Loop and legacy qualifiers come from the arbitration controller
    assign cfg_set = arb_treeid_timeout_evt && in_bus_loop && legacy_node_present;
    assign sto_set = state_timeout_evt;
    assign cpd_set = cable_power_drop_evt;
    assign pev_set = port_change_evt
                   || (resume_irq_enable_q && resume_start_evt)
                   || (resume_irq_enable_q && !link_power_status_in
                       && (cfg_set || cpd_set || sto_set));

    psr_w1c_flag #(.RESET_VAL(RST_CFG_TIMEOUT)) u_cfg_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_evt (cfg_set),
        .clr_w1c (wr_event && w1c(reg_wdata, BIT_CFG_TIMEOUT)),
        .flag_q  (config_timeout_flag_q)
    );

    psr_w1c_flag #(.RESET_VAL(RST_CABLE_PWR)) u_cpd_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_evt (cpd_set),
        .clr_w1c (wr_event && w1c(reg_wdata, BIT_CABLE_PWR)),
        .flag_q  (cable_power_drop_flag)
    );

    psr_w1c_flag #(.RESET_VAL(RST_STATE_TO)) u_sto_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_evt (sto_set),
        .clr_w1c (wr_event && w1c(reg_wdata, BIT_STATE_TIMEOUT)),
        .flag_q  (state_timeout_flag)
    );

    psr_w1c_flag #(.RESET_VAL(RST_PORT_EVENT)) u_pev_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_evt (pev_set),
        .clr_w1c (wr_event && w1c(reg_wdata, BIT_PORT_EVENT)),
        .flag_q  (port_event_flag)
    );

    // ============================================================
    // Self-ID fields and link interface state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            selfid_link_active_q  <= 1'b0;
            selfid_contender_q    <= RST_CONTENDER;
            selfid_power_class_q  <= power_class_strap_inputs;
            link_if_operational_q <= 1'b0;
        end else begin
            selfid_link_active_q  <= link_active_ctrl_q && link_power_status_in;
            selfid_contender_q    <= contender_q;
            selfid_power_class_q  <= power_class_q;
            // Control bit deliberately ignored: only the power status counts
            link_if_operational_q <= link_power_status_in;
        end
    end

    // Wake stands while the link is down, resume is enabled and a config, cable power or state timeout flag is pending
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link_wake_output_q <= 1'b0;
        end else begin
            link_wake_output_q <= resume_irq_enable_q && !link_power_status_in
                && (config_timeout_flag_q || cable_power_drop_flag
                    || state_timeout_flag);
        end
    end

    // ============================================================
    // Bus reset sequencer
    // State timeout resets at once; a software request waits its turn
    assign reset_start = (rs_q == PSR_RS_IDLE)
                      && (sto_set || (short_reset_request_q && arb_opportunity));
    assign start_long  = sto_set || legacy_node_present;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rs_q               <= PSR_RS_IDLE;
            rs_cnt_q           <= '0;
            bus_reset_active_q <= 1'b0;
            bus_reset_long_q   <= 1'b0;
        end else begin
            unique case (rs_q)
                PSR_RS_IDLE: begin
                    if (reset_start) begin
                        rs_q               <= PSR_RS_ACTIVE;
                        bus_reset_active_q <= 1'b1;
                        bus_reset_long_q   <= start_long;
                        rs_cnt_q           <= start_long
                            ? RST_CNT_W'(LONG_RESET_CYCLES - 1)
                            : RST_CNT_W'(SHORT_RESET_CYC - 1);
                    end
                end
                PSR_RS_ACTIVE: begin
                    if (rs_cnt_q == '0) begin
                        rs_q               <= PSR_RS_IDLE;
                        bus_reset_active_q <= 1'b0;
                        bus_reset_long_q   <= 1'b0;
                    end else begin
                        rs_cnt_q <= rs_cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Read path; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata_q  <= RDATA_IDLE;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= RDATA_IDLE;
                unique case (reg_addr)
                    ADDR_SELFID_CTRL: begin
                        reg_rdata_q[BIT_LINK_ACTIVE]         <= link_active_ctrl_q;
                        reg_rdata_q[BIT_CONTENDER]           <= contender_q;
                        reg_rdata_q[BIT_JITTER_HI:BIT_JITTER_LO] <= JITTER_VALUE;
                        reg_rdata_q[BIT_PWR_HI:BIT_PWR_LO]   <= power_class_q;
                    end
                    ADDR_EVENT_CTRL: begin
                        reg_rdata_q[BIT_RESUME_IE]     <= resume_irq_enable_q;
                        reg_rdata_q[BIT_SHORT_RST_REQ] <= short_reset_request_q;
                        reg_rdata_q[BIT_CFG_TIMEOUT]   <= config_timeout_flag_q;
                        reg_rdata_q[BIT_CABLE_PWR]     <= cable_power_drop_flag;
                        reg_rdata_q[BIT_STATE_TIMEOUT] <= state_timeout_flag;
                        reg_rdata_q[BIT_PORT_EVENT]    <= port_event_flag;
                    end
                    default: begin
                        reg_rdata_q <= RDATA_IDLE;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Checks
    // The first edge after reset still shows the reset value, not the AND
    selfid_link_and_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |->
        selfid_link_active_q == ($past(link_active_ctrl_q) && $past(link_power_status_in)))
        else $error("self-ID link bit wrong");

    link_ctrl_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (bus_reset_evt && !wr_selfid) |=> link_active_ctrl_q == $past(link_active_ctrl_q))
        else $error("link-active control changed by bus reset");

    link_if_power_a: assert property (@(posedge ref_clk) disable iff (rst)
        (link_power_status_in && !link_active_ctrl_q) |=> link_if_operational_q)
        else $error("link interface not following power status");

    contender_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !wr_selfid |=> contender_q == $past(contender_q))
        else $error("contender changed without write");

    jitter_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_SELFID_CTRL) |=>
            reg_rdata_q[BIT_JITTER_HI:BIT_JITTER_LO] == JITTER_VALUE)
        else $error("jitter field nonzero");

    pwr_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 selfid_power_class_q == $past(power_class_q))
        else $error("self-ID power class mismatch");

    resume_pev_a: assert property (@(posedge ref_clk) disable iff (rst)
        (resume_irq_enable_q && resume_start_evt) |=> port_event_flag)
        else $error("resume start did not set port event");

    short_rst_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reset_start && !start_long) |=> bus_reset_active_q [*8] ##1 !bus_reset_long_q)
        else $error("short bus reset wrong");

    short_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
        (bus_reset_evt && !wr_event) |=> !short_reset_request_q)
        else $error("short reset request not cleared");

    legacy_long_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reset_start && legacy_node_present) |=> bus_reset_long_q)
        else $error("legacy network did not get long reset");

    cfg_set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_set |=> config_timeout_flag_q)
        else $error("config timeout flag lost");

    cfg_qual_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(config_timeout_flag_q) |-> $past(in_bus_loop && legacy_node_present))
        else $error("config flag set without loop and legacy node");

    cfg_w0_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_event && !reg_wdata[BIT_CFG_TIMEOUT] && config_timeout_flag_q)
            |=> config_timeout_flag_q)
        else $error("writing zero cleared config flag");

    wake_a: assert property (@(posedge ref_clk) disable iff (rst)
        (config_timeout_flag_q && resume_irq_enable_q && !link_power_status_in)
            |=> link_wake_output_q)
        else $error("link wake not raised");

    sto_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_timeout_evt && rs_q == PSR_RS_IDLE) |=> bus_reset_active_q && bus_reset_long_q)
        else $error("state timeout did not reset bus");

    short_reset_cv: cover property (@(posedge ref_clk) disable iff (rst)
        reset_start && !start_long);
    long_reset_cv: cover property (@(posedge ref_clk) disable iff (rst)
        reset_start && legacy_node_present);
    wake_cv: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(link_wake_output_q));
    cfg_clash_cv: cover property (@(posedge ref_clk) disable iff (rst)
        cfg_set && wr_event && reg_wdata[BIT_CFG_TIMEOUT]);

endmodule

// file: bench/psr_link_model.sv
`timescale 1ns/10ps
// ============================================================
// Link controller model: sleeps on command, wakes on link wake
module psr_link_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       sleep_req,
    input  wire logic [7:0] wake_delay,
    input  wire logic       link_wake_output_q,
    output logic            link_power_status_in
);
    logic [7:0] wait_q;
    logic       woke_q;

    // A real controller needs time to power up; delay 0 models a prompt one
    always_ff @(posedge ref_clk) begin
        if (rst || !sleep_req) begin
            wait_q <= 8'h00;
            woke_q <= 1'b0;
        end else if (link_wake_output_q && !woke_q) begin
            wait_q <= wait_q + 8'h01;
            woke_q <= (wait_q >= wake_delay);
        end
    end

    assign link_power_status_in = !sleep_req || woke_q;
endmodule

// file: bench/psr_regs_tb.sv
`timescale 1ns/10ps
module psr_regs_tb;
    import psr_pkg::*;
    localparam int         LONG_CYC = 20;
    localparam logic [2:0] STRAPS   = 3'h5;

    logic       ref_clk, rst, reg_wr, reg_rd, reg_rvalid_q, link_pwr, sleep_req;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, wake_delay, rd_val;
    logic [2:0] straps, sid_pwr;
    logic       resume_evt, port_evt, arb_to, in_loop, legacy, state_to, cable_evt;
    logic       arb_opp, bus_rst, sid_link, sid_cont, link_op, wake;
    logic       rst_act, rst_long, sreq, cfg_flag;
    int         num_errors;
    int         n_compared;

    psr_regs #(.LONG_RESET_CYCLES(LONG_CYC)) uut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .link_power_status_in(link_pwr),
        .power_class_strap_inputs(straps), .resume_start_evt(resume_evt),
        .port_change_evt(port_evt), .arb_treeid_timeout_evt(arb_to),
        .in_bus_loop(in_loop), .legacy_node_present(legacy),
        .state_timeout_evt(state_to), .cable_power_drop_evt(cable_evt),
        .arb_opportunity(arb_opp), .bus_reset_evt(bus_rst),
        .selfid_link_active_q(sid_link), .selfid_contender_q(sid_cont),
        .selfid_power_class_q(sid_pwr), .link_if_operational_q(link_op),
        .link_wake_output_q(wake), .bus_reset_active_q(rst_act),
        .bus_reset_long_q(rst_long), .short_reset_request_q(sreq),
        .config_timeout_flag_q(cfg_flag));

    psr_link_model link_model (
        .ref_clk(ref_clk), .rst(rst), .sleep_req(sleep_req), .wake_delay(wake_delay),
        .link_wake_output_q(wake), .link_power_status_in(link_pwr));

    always #5 ref_clk = ~ref_clk;

    // ============================================================
    // Access tasks; all start and end just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Idle cycle after each write so the strobe is never driven twice in one step
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid_q !== 1'b1; i++) tick(1);
        rd_val = reg_rdata_q;
        check(reg_rvalid_q, 1'b1, "read valid");
        check(rd_val, exp, "register read");
        tick(1);
    endtask

    task automatic run_reset(input logic exp_long, input int exp_len);
        int n;
        n = 0;
        for (int i = 0; i < 10 && rst_act !== 1'b1; i++) tick(1);
        check(rst_long, exp_long, "reset kind");
        check(sreq, 1'b0, "request after start");
        while (rst_act === 1'b1 && n < 400) begin
            n++;
            tick(1);
        end
        check(8'(n), 8'(exp_len), "reset length");
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ============================================================
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    // ============================================================
    // Main sequence
    initial begin
        {ref_clk, reg_wr, reg_rd, resume_evt, port_evt, arb_to, in_loop} = 7'h00;
        {legacy, state_to, cable_evt, arb_opp, bus_rst, sleep_req} = 6'h00;
        {reg_addr, reg_wdata, wake_delay} = 20'h00000;
        {num_errors, n_compared} = 64'h0;
        straps = STRAPS;
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        straps = 3'h2;
        tick(2);
        expect_reg(ADDR_SELFID_CTRL, 8'h85);
        expect_reg(ADDR_EVENT_CTRL, 8'h10);
        check(sid_link, 1'b1, "self-ID link");
        check(sid_pwr, STRAPS, "self-ID power");
        reg_write(4'hA, 8'hFF);
        expect_reg(4'hA, 8'h00);
        expect_reg(ADDR_SELFID_CTRL, 8'h85);
        // Link power off and on, then link-active control cleared
        sleep_req = 1'b1;
        tick(3);
        check(sid_link, 1'b0, "self-ID link, power off");
        check(link_op, 1'b0, "link interface, power off");
        sleep_req = 1'b0;
        tick(3);
        check(sid_link, 1'b1, "self-ID link, power on");
        reg_write(ADDR_SELFID_CTRL, 8'h05);
        tick(2);
        check(sid_link, 1'b0, "self-ID link, control off");
        check(link_op, 1'b1, "link interface, control off");
        expect_reg(ADDR_SELFID_CTRL, 8'h05);
        reg_write(ADDR_SELFID_CTRL, 8'h7A);
        expect_reg(ADDR_SELFID_CTRL, 8'h42);
        check(sid_cont, 1'b1, "self-ID contender");
        check(sid_pwr, 3'h2, "self-ID power");
        reg_write(ADDR_SELFID_CTRL, 8'hC3);
        reg_write(ADDR_EVENT_CTRL, 8'h80);
        bus_rst = 1'b1;
        tick(1);
        bus_rst = 1'b0;
        tick(2);
        expect_reg(ADDR_SELFID_CTRL, 8'hC3);
        expect_reg(ADDR_EVENT_CTRL, 8'h90);
        // Short reset waits for its opportunity
        reg_write(ADDR_EVENT_CTRL, 8'hC0);
        tick(5);
        check(sreq, 1'b1, "request pending");
        check(rst_act, 1'b0, "no reset before opportunity");
        arb_opp = 1'b1;
        run_reset(1'b0, SHORT_RESET_CYC);
        arb_opp = 1'b0;
        reg_write(ADDR_EVENT_CTRL, 8'hC0);
        bus_rst = 1'b1;
        tick(1);
        bus_rst = 1'b0;
        tick(2);
        check(sreq, 1'b0, "request after bus reset");
        legacy = 1'b1;
        reg_write(ADDR_EVENT_CTRL, 8'hC0);
        arb_opp = 1'b1;
        run_reset(1'b1, LONG_CYC);
        arb_opp = 1'b0;
        state_to = 1'b1;
        tick(1);
        state_to = 1'b0;
        run_reset(1'b1, LONG_CYC);
        expect_reg(ADDR_EVENT_CTRL, 8'h98);
        reg_write(ADDR_EVENT_CTRL, 8'h98);
        // Config time-out only for a loop node with legacy nodes present
        for (int i = 1; i < 4; i++) begin
            in_loop = i[0];
            legacy = i[1];
            arb_to = 1'b1;
            tick(1);
            arb_to = 1'b0;
            tick(2);
            check(cfg_flag, 8'(i == 3), "config flag");
        end
        check(wake, 1'b0, "wake while link up");
        reg_write(ADDR_EVENT_CTRL, 8'h80);
        check(cfg_flag, 1'b1, "flag after zero write");
        reg_wdata = 8'hA0;
        reg_wr = 1'b1;
        arb_to = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        arb_to = 1'b0;
        tick(1);
        check(cfg_flag, 1'b1, "flag after set and clear");
        reg_write(ADDR_EVENT_CTRL, 8'hA0);
        check(cfg_flag, 1'b0, "flag after one write");
        // Resume start raises port event only when enabled
        reg_write(ADDR_EVENT_CTRL, 8'h00);
        resume_evt = 1'b1;
        tick(1);
        resume_evt = 1'b0;
        expect_reg(ADDR_EVENT_CTRL, 8'h00);
        reg_write(ADDR_EVENT_CTRL, 8'h80);
        resume_evt = 1'b1;
        tick(1);
        resume_evt = 1'b0;
        expect_reg(ADDR_EVENT_CTRL, 8'h84);
        reg_write(ADDR_EVENT_CTRL, 8'h84);
        // Time-out with link asleep wakes the slow controller
        wake_delay = 8'h06;
        sleep_req = 1'b1;
        tick(3);
        check(wake, 1'b0, "wake with no flag");
        arb_to = 1'b1;
        tick(1);
        arb_to = 1'b0;
        for (int i = 0; i < 4 && wake !== 1'b1; i++) tick(1);
        check(wake, 1'b1, "wake raised");
        for (int i = 0; i < 30 && link_op !== 1'b1; i++) tick(1);
        sleep_req = 1'b0;
        tick(3);
        check(wake, 1'b0, "wake after link up");
        expect_reg(ADDR_EVENT_CTRL, 8'hA4);
        // Cable power drop with the link asleep also raises the port event
        reg_write(ADDR_EVENT_CTRL, 8'hA4);
        sleep_req = 1'b1;
        cable_evt = 1'b1;
        tick(1);
        cable_evt = 1'b0;
        expect_reg(ADDR_EVENT_CTRL, 8'h94);
        wrap_up();
    end
endmodule
